// ---- src/adr_read_handler.sv ----
// Our own choices: the placing of the registers and the APB interface to the registers.
`default_nettype none
module adr_read_handler (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire adr_pkg::adr_apb_req_t apb_i,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output adr_pkg::adr_media_cmd_t media_o,
  input wire adr_pkg::adr_media_rsp_t media_i,
  input wire logic dmack_pin,
  output logic dmarq,
  output logic [15:0] dd_word,
  output logic intrq
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [16:0] adr_count(input logic [15:0] v, input logic wide);
    logic [16:0] c;
    c = {1'b0, v};
    if (wide && v == 16'h0000)
      c = 17'h10000;
    else if (!wide && v[7:0] == 8'h00)
      c = 17'h00100;
    else if (!wide)
      c = {9'h000, v[7:0]};
    return c;
  endfunction : adr_count

  // Shift keeps the previous write for the 48-bit commands
  function automatic adr_pkg::adr_tf_t adr_push(input adr_pkg::adr_tf_t t, input logic [7:0] v);
    adr_pkg::adr_tf_t r;
    r.prev = t.cur;
    r.cur = v;
    return r;
  endfunction : adr_push

  function automatic logic [7:0] adr_pick(input adr_pkg::adr_tf_t t, input logic hob);
    return hob ? t.prev : t.cur;
  endfunction : adr_pick

  adr_pkg::adr_state_t s_q;
  adr_pkg::adr_state_t s_d;

  assign prdata = s_q.prdata;
  assign pready = s_q.pready;
  assign pslverr = s_q.pslverr;
  assign media_o = s_q.med;
  assign dmarq = s_q.dmarq;
  assign dd_word = s_q.dd;
  assign intrq = s_q.intrq;

  always_comb
  begin
    logic acc;
    logic wr;
    logic rd_stat;
    logic hob;
    logic [7:0] status;
    logic [7:0] rdata;
    logic mapped;
    logic ack_rise;
    logic irq_set;
    logic [7:0] op;
    logic [47:0] fin_addr;
    acc = 1'b0;
    wr = 1'b0;
    rd_stat = 1'b0;
    hob = 1'b0;
    status = 8'h00;
    rdata = 8'h00;
    mapped = 1'b0;
    ack_rise = 1'b0;
    irq_set = 1'b0;
    op = 8'h00;
    fin_addr = 48'h0;
    s_d = s_q;
    s_d.med.start = 1'b0;

    // ----------------------------------------------------------------
    // Acknowledge pin: three stages, change taken once stages 2 and 3 agree
    // ----------------------------------------------------------------
    s_d.ack_sync = {s_q.ack_sync[1:0], dmack_pin};
    if (s_q.ack_sync[2] == s_q.ack_sync[1])
    begin
      s_d.ack_stable = s_q.ack_sync[2];
      ack_rise = s_q.ack_sync[2] & ~s_q.ack_stable;
    end

    // ----------------------------------------------------------------
    // Register file
    // ----------------------------------------------------------------
    hob = s_q.devctl[adr_pkg::ADR_DC_HOB];
    status[adr_pkg::ADR_ST_BSY] = (s_q.phase == adr_pkg::ADR_FILL)
                                  || (s_q.phase == adr_pkg::ADR_SEND);
    status[adr_pkg::ADR_ST_RDY] = 1'b1;
    status[adr_pkg::ADR_ST_SRV] = s_q.srv;
    status[adr_pkg::ADR_ST_DRQ] = s_q.dmarq;
    status[adr_pkg::ADR_ST_ERR] = |s_q.error;
    mapped = 1'b1;
    case (apb_i.paddr)
      adr_pkg::ADR_OFF_FEATURE: rdata = 8'h00;
      adr_pkg::ADR_OFF_SECCNT: rdata = adr_pick(s_q.seccnt, hob);
      adr_pkg::ADR_OFF_SECNUM: rdata = adr_pick(s_q.secnum, hob);
      adr_pkg::ADR_OFF_CYLLO: rdata = adr_pick(s_q.cyllo, hob);
      adr_pkg::ADR_OFF_CYLHI: rdata = adr_pick(s_q.cylhi, hob);
      adr_pkg::ADR_OFF_DEVHEAD: rdata = s_q.devhead;
      adr_pkg::ADR_OFF_CMDSTAT: rdata = status;
      adr_pkg::ADR_OFF_ERROR: rdata = s_q.error;
      adr_pkg::ADR_OFF_DEVCTL: rdata = s_q.devctl;
      default: mapped = 1'b0;
    endcase

    // No wait state, yet read data and pready both come from flops
    s_d.pready = apb_i.psel & ~apb_i.penable;
    if (apb_i.psel && !apb_i.penable)
    begin
      s_d.prdata = {24'h000000, rdata};
      s_d.pslverr = ~mapped;
    end
    acc = apb_i.psel & apb_i.penable & s_q.pready;
    wr = acc & apb_i.pwrite & ~s_q.pslverr;
    rd_stat = acc & ~apb_i.pwrite & (apb_i.paddr == adr_pkg::ADR_OFF_CMDSTAT);
    op = apb_i.pwdata[7:0];

    if (wr)
    begin
      case (apb_i.paddr)
        adr_pkg::ADR_OFF_FEATURE: s_d.feat = adr_push(s_q.feat, op);
        adr_pkg::ADR_OFF_SECCNT: s_d.seccnt = adr_push(s_q.seccnt, op);
        adr_pkg::ADR_OFF_SECNUM: s_d.secnum = adr_push(s_q.secnum, op);
        adr_pkg::ADR_OFF_CYLLO: s_d.cyllo = adr_push(s_q.cyllo, op);
        adr_pkg::ADR_OFF_CYLHI: s_d.cylhi = adr_push(s_q.cylhi, op);
        adr_pkg::ADR_OFF_DEVHEAD: s_d.devhead = op;
        adr_pkg::ADR_OFF_DEVCTL: s_d.devctl = op;
        default: s_d.devctl = s_d.devctl;
      endcase
    end

    // ----------------------------------------------------------------
    // Command launch
    // ----------------------------------------------------------------
    if (wr && apb_i.paddr == adr_pkg::ADR_OFF_CMDSTAT && s_q.phase == adr_pkg::ADR_IDLE)
    begin
      s_d.error = adr_pkg::ADR_ERROR_RST;
      s_d.fail = 1'b0;
      s_d.srv = 1'b0;
      s_d.widx = '0;
      s_d.ext = 1'b0;
      s_d.queued = 1'b0;
      s_d.log = 1'b0;
      s_d.tag = s_q.seccnt.cur[7:3];
      // Head nibble becomes LBA 27:24 or stays a head number for CHS
      s_d.cur_addr = {20'h00000, s_q.devhead[3:0], s_q.cylhi.cur, s_q.cyllo.cur,
                      s_q.secnum.cur};
      s_d.med.chs = ~s_q.devhead[adr_pkg::ADR_DH_LBA];
      s_d.phase = adr_pkg::ADR_FILL;
      case (op)
        adr_pkg::ADR_OP_READ_DMA, adr_pkg::ADR_OP_READ_DMA_NR:
          s_d.rem = adr_count({8'h00, s_q.seccnt.cur}, 1'b0);
        adr_pkg::ADR_OP_READ_DMA_EXT:
        begin
          s_d.ext = 1'b1;
          s_d.rem = adr_count({s_q.seccnt.prev, s_q.seccnt.cur}, 1'b1);
        end
        adr_pkg::ADR_OP_READ_DMA_Q:
        begin
          s_d.queued = 1'b1;
          s_d.rem = adr_count({8'h00, s_q.feat.cur}, 1'b0);
        end
        adr_pkg::ADR_OP_READ_DMA_Q_EXT:
        begin
          s_d.queued = 1'b1;
          s_d.ext = 1'b1;
          s_d.rem = adr_count({s_q.feat.prev, s_q.feat.cur}, 1'b1);
        end
        adr_pkg::ADR_OP_READ_LOG_EXT:
        begin
          s_d.log = 1'b1;
          s_d.ext = 1'b1;
          s_d.rem = {1'b0, s_q.secnum.prev, s_q.seccnt.cur};
          s_d.cur_addr = {24'h000000, s_q.secnum.cur, s_q.cyllo.prev,
                          s_q.cyllo.cur};
        end
        default:
        begin
          s_d.error[adr_pkg::ADR_ER_ABT] = 1'b1;
          s_d.phase = adr_pkg::ADR_IDLE;
          irq_set = 1'b1;
        end
      endcase
      if (op == adr_pkg::ADR_OP_READ_DMA_EXT || op == adr_pkg::ADR_OP_READ_DMA_Q_EXT)
      begin
        s_d.cur_addr = {s_q.cylhi.prev, s_q.cyllo.prev, s_q.secnum.prev,
                        s_q.cylhi.cur, s_q.cyllo.cur, s_q.secnum.cur};
        s_d.med.chs = 1'b0;
      end
      // A zero-length log request has nothing to return
      if (op == adr_pkg::ADR_OP_READ_LOG_EXT && s_d.rem == 17'h00000)
      begin
        s_d.error[adr_pkg::ADR_ER_ABT] = 1'b1;
        s_d.phase = adr_pkg::ADR_IDLE;
        irq_set = 1'b1;
      end
      if (s_d.phase == adr_pkg::ADR_FILL)
      begin
        s_d.med.start = 1'b1;
        s_d.med.lba = s_d.cur_addr;
        s_d.med.count = s_d.rem;
        // Without data at hand the queued command frees the bus
        if (s_d.queued && !media_i.data_ready)
        begin
          s_d.phase = adr_pkg::ADR_REL;
          s_d.seccnt.cur = {s_q.seccnt.cur[7:3], adr_pkg::ADR_SC_RELEASE};
          s_d.srv = 1'b0;
          irq_set = 1'b1;
        end
      end
    end

    // ----------------------------------------------------------------
    // Transfer sequencer
    // ----------------------------------------------------------------
    case (s_q.phase)
      adr_pkg::ADR_IDLE:
        s_d.dmarq = 1'b0;
      adr_pkg::ADR_REL:
        if (media_i.data_ready)
        begin
          s_d.srv = 1'b1;
          s_d.phase = adr_pkg::ADR_SRVW;
          irq_set = 1'b1;
        end
      adr_pkg::ADR_SRVW:
        if (wr && apb_i.paddr == adr_pkg::ADR_OFF_CMDSTAT && op == adr_pkg::ADR_OP_SERVICE)
        begin
          s_d.phase = adr_pkg::ADR_FILL;
          s_d.srv = 1'b0;
          s_d.seccnt.cur = {s_q.tag, 3'h0};
        end
      adr_pkg::ADR_FILL:
        if (media_i.valid && s_q.med.ready)
        begin
          if (media_i.err)
          begin
            // Failing sector is not sent; remaining count is left as is
            s_d.fail = 1'b1;
            s_d.error[adr_pkg::ADR_ER_UNC] = 1'b1;
            s_d.phase = adr_pkg::ADR_IDLE;
          end
          else
          begin
            s_d.dd = media_i.word;
            s_d.dmarq = 1'b1;
            s_d.phase = adr_pkg::ADR_SEND;
          end
        end
      adr_pkg::ADR_SEND:
        // No release path from here until the last word is taken
        if (ack_rise)
        begin
          s_d.dmarq = 1'b0;
          s_d.widx = s_q.widx + 1'b1;
          s_d.phase = adr_pkg::ADR_FILL;
          if (s_q.widx == adr_pkg::ADR_LAST_WORD)
          begin
            s_d.rem = s_q.rem - 17'h00001;
            s_d.last_addr = s_q.cur_addr;
            s_d.cur_addr = s_q.cur_addr + 48'h000000000001;
            if (s_q.log)
              irq_set = 1'b1;
            if (s_q.rem == 17'h00001)
              s_d.phase = adr_pkg::ADR_IDLE;
          end
        end
      default:
        s_d.phase = adr_pkg::ADR_IDLE;
    endcase

    // ----------------------------------------------------------------
    // Completion: load the task file with the result, except for log reads
    // ----------------------------------------------------------------
    if ((s_q.phase == adr_pkg::ADR_FILL || s_q.phase == adr_pkg::ADR_SEND)
        && s_d.phase == adr_pkg::ADR_IDLE)
    begin
      // Plain 28-bit reads report the last good sector, the others the failing one
      fin_addr = (s_d.fail && (s_q.ext || s_q.queued)) ? s_q.cur_addr
                                                      : s_d.last_addr;
      if (!s_q.log)
      begin
        if (!s_q.ext)
          s_d.seccnt.cur = s_d.rem[7:0];
        s_d.secnum = '{prev: fin_addr[31:24], cur: fin_addr[7:0]};
        s_d.cyllo = '{prev: fin_addr[39:32], cur: fin_addr[15:8]};
        s_d.cylhi = '{prev: fin_addr[47:40], cur: fin_addr[23:16]};
        if (!s_q.ext)
          s_d.devhead[3:0] = fin_addr[27:24];
      end
      if (s_q.queued)
      begin
        s_d.seccnt.cur = {s_q.tag, adr_pkg::ADR_SC_COMPLETE};
        s_d.srv = 1'b0;
      end
      // Log reads already signalled per sector unless a sector failed
      if (!s_q.log || s_d.fail)
        irq_set = 1'b1;
    end

    // Host ack of the interrupt is a status read; a new event wins
    if (rd_stat)
      s_d.intrq = 1'b0;
    if (irq_set)
      s_d.intrq = 1'b1;

    s_d.med.ready = (s_d.phase == adr_pkg::ADR_FILL);
  end

  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      s_q <= '0;
      s_q.phase <= adr_pkg::ADR_IDLE;
      s_q.devhead <= adr_pkg::ADR_DEVHEAD_RST;
      s_q.devctl <= adr_pkg::ADR_DEVCTL_RST;
      s_q.error <= adr_pkg::ADR_ERROR_RST;
    end
    else
      s_q <= s_d;
  end

endmodule : adr_read_handler
`default_nettype wire

// ---- src/adr_pkg.sv ----
`default_nettype none
package adr_pkg;

  // ----------------------------------------------------------------
  // Register offsets (byte addresses on APB)
  // ----------------------------------------------------------------
  localparam logic [7:0] ADR_OFF_FEATURE = 8'h04;
  localparam logic [7:0] ADR_OFF_SECCNT = 8'h08;
  localparam logic [7:0] ADR_OFF_SECNUM = 8'h0C;
  localparam logic [7:0] ADR_OFF_CYLLO = 8'h10;
  localparam logic [7:0] ADR_OFF_CYLHI = 8'h14;
  localparam logic [7:0] ADR_OFF_DEVHEAD = 8'h18;
  localparam logic [7:0] ADR_OFF_CMDSTAT = 8'h1C;
  localparam logic [7:0] ADR_OFF_ERROR = 8'h20;
  localparam logic [7:0] ADR_OFF_DEVCTL = 8'h24;

  // ----------------------------------------------------------------
  // Opcodes
  // ----------------------------------------------------------------
  localparam logic [7:0] ADR_OP_READ_DMA = 8'hC8;
  localparam logic [7:0] ADR_OP_READ_DMA_NR = 8'hC9;
  localparam logic [7:0] ADR_OP_READ_DMA_EXT = 8'h25;
  localparam logic [7:0] ADR_OP_READ_DMA_Q = 8'hC7;
  localparam logic [7:0] ADR_OP_READ_DMA_Q_EXT = 8'h26;
  localparam logic [7:0] ADR_OP_READ_LOG_EXT = 8'h2F;
  localparam logic [7:0] ADR_OP_SERVICE = 8'hA2;

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int ADR_ST_BSY = 7;
  localparam int ADR_ST_RDY = 6;
  localparam int ADR_ST_SRV = 4;
  localparam int ADR_ST_DRQ = 3;
  localparam int ADR_ST_ERR = 0;
  localparam int ADR_ER_UNC = 6;
  localparam int ADR_ER_ABT = 2;
  localparam int ADR_DC_HOB = 7;
  localparam int ADR_DH_LBA = 6;
  localparam logic [2:0] ADR_SC_RELEASE = 3'h4;
  localparam logic [2:0] ADR_SC_COMPLETE = 3'h3;
  localparam logic [7:0] ADR_DEVHEAD_RST = 8'h00;
  localparam logic [7:0] ADR_DEVCTL_RST = 8'h00;
  localparam logic [7:0] ADR_ERROR_RST = 8'h00;
  localparam int ADR_WIDX_W = 8;
  localparam logic [ADR_WIDX_W-1:0] ADR_LAST_WORD = 8'hFF;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0] prev;
    logic [7:0] cur;
  } adr_tf_t;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } adr_apb_req_t;

  typedef struct packed {
    logic start;
    logic chs;
    logic [47:0] lba;
    logic [16:0] count;
    logic ready;
  } adr_media_cmd_t;

  typedef struct packed {
    logic valid;
    logic [15:0] word;
    logic err;
    logic data_ready;
  } adr_media_rsp_t;

  typedef enum logic [2:0] {ADR_IDLE, ADR_FILL, ADR_SEND, ADR_REL, ADR_SRVW} adr_phase_t;

  typedef struct packed {
    adr_phase_t phase;
    adr_tf_t feat;
    adr_tf_t seccnt;
    adr_tf_t secnum;
    adr_tf_t cyllo;
    adr_tf_t cylhi;
    logic [7:0] devhead;
    logic [7:0] devctl;
    logic [7:0] error;
    logic ext;
    logic queued;
    logic log;
    logic fail;
    logic srv;
    logic intrq;
    logic [4:0] tag;
    logic [16:0] rem;
    logic [ADR_WIDX_W-1:0] widx;
    logic [47:0] cur_addr;
    logic [47:0] last_addr;
    logic [15:0] dd;
    logic dmarq;
    logic [2:0] ack_sync;
    logic ack_stable;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    adr_media_cmd_t med;
  } adr_state_t;

endpackage : adr_pkg
`default_nettype wire

// ---- bench/adr_read_handler_properties.sv ----
`default_nettype none
module adr_read_handler_props (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire adr_pkg::adr_apb_req_t apb_i,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire adr_pkg::adr_media_cmd_t media_o,
  input wire adr_pkg::adr_media_rsp_t media_i,
  input wire logic dmack_pin,
  input wire logic dmarq,
  input wire logic [15:0] dd_word,
  input wire logic intrq
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (sys_rst);
  // ----------------------------------------------------------------
  // Steps of a bus access and of a media word hand-off
  // ----------------------------------------------------------------
  sequence s_setup;
    apb_i.psel && !apb_i.penable;
  endsequence
  sequence s_taken;
    media_i.valid && media_o.ready && !media_i.err;
  endsequence
  sequence s_bad;
    media_i.valid && media_o.ready && media_i.err;
  endsequence
  chk_apb_wait: assert property (s_setup |=> pready ##1 !pready)
    else $error("pready not a single cycle after setup");
  chk_bad_addr: assert property (pready && apb_i.paddr > 8'h24 |-> pslverr)
    else $error("unmapped address without slave error");
  chk_good_addr: assert property (pready && apb_i.paddr inside {[8'h04:8'h24]}
    && apb_i.paddr[1:0] == 2'h0 |-> !pslverr)
    else $error("slave error on a mapped address");
  chk_rdata_pad: assert property (pready |-> prdata[31:8] == 24'h000000)
    else $error("read data upper bytes not zero");
  chk_word_out: assert property (s_taken |=> dmarq && !media_o.ready
    && dd_word == $past(media_i.word))
    else $error("media word not offered on the data port");
  chk_word_hold: assert property (dmarq && !dmack_pin |=> dmarq && $stable(dd_word))
    else $error("data request dropped before acknowledge");
  chk_ack_drop: assert property (dmarq && dmack_pin |-> ##[1:6] !dmarq)
    else $error("data request not withdrawn after acknowledge");
  chk_err_stop: assert property (s_bad |=> !dmarq [*8])
    else $error("word sent after uncorrectable sector");
  chk_cmd_count: assert property (media_o.start |->
    media_o.count inside {[17'h00001:17'h10000]})
    else $error("launched sector count out of range");
endmodule : adr_read_handler_props
bind adr_read_handler adr_read_handler_props i_adr_read_handler_props (.core_clk, .sys_rst,
  .apb_i, .prdata, .pready, .pslverr, .media_o, .media_i, .dmack_pin, .dmarq, .dd_word, .intrq);
`default_nettype wire

// ---- bench/adr_host_dma.sv ----
`default_nettype none
module adr_host_dma (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic dmarq,
  input wire logic [15:0] dd_word,
  input wire logic [3:0] dly,
  output logic dmack_pin,
  output int words,
  output logic [15:0] last
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] wait_q;
  // ----------------------------------------------------------------
  // Slave-DMA channel
  // ----------------------------------------------------------------
  // Three idle cycles at least, so the device sees acknowledge low before the next word
  always @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      dmack_pin <= 1'b0;
      wait_q <= 4'h0;
      words <= 0;
    end
    else if (dmack_pin)
    begin
      if (!dmarq) dmack_pin <= 1'b0;
    end
    else if (dmarq && wait_q >= dly + 4'h3)
    begin
      dmack_pin <= 1'b1;
      words <= words + 1;
      last <= dd_word;
      wait_q <= 4'h0;
    end
    else if (dmarq) wait_q <= wait_q + 4'h1;
  end
endmodule : adr_host_dma
`default_nettype wire

// ---- bench/adr_read_handler_bench.sv ----
`default_nettype none
module adr_read_handler_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  adr_pkg::adr_apb_req_t apb_i = '0;
  adr_pkg::adr_media_cmd_t media_o;
  adr_pkg::adr_media_rsp_t media_i;
  logic [31:0] prdata;
  logic pready, pslverr, dmack_pin, dmarq, intrq, irq_d, se;
  logic src_on = 1'b0;
  logic dready = 1'b0;
  logic [15:0] dd_word, last;
  logic [7:0] v;
  logic [3:0] dly = 4'h4;
  int words, n0, i0;
  int irqs = 0, err_total = 0, compares = 0, cyc = 0, wi = 0, err_at = -1;
  adr_read_handler i_adr_read_handler (.core_clk, .sys_rst, .apb_i, .prdata, .pready,
    .pslverr, .media_o, .media_i, .dmack_pin, .dmarq, .dd_word, .intrq);
  adr_host_dma i_adr_host_dma (.core_clk, .sys_rst, .dmarq, .dd_word, .dly, .dmack_pin,
    .words, .last);
  // ----------------------------------------------------------------
  // Media source and monitors
  // ----------------------------------------------------------------
  // Word value is its index in the command, so a skipped or repeated word shows
  always_comb media_i = '{src_on, wi[15:0], wi == err_at, dready};
  initial forever #12.5 core_clk = ~core_clk;
  always @(posedge core_clk)
  begin
    cyc++;
    irq_d <= intrq;
    if (intrq && !irq_d) irqs++;
    if (src_on && media_o.ready) wi <= wi + 1;
    if (cyc == 60000)
    begin
      err_total++;
      results();
    end
  end
  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task results;
    $display("compares %0d errors %0d", compares, err_total);
    if (err_total == 0 && compares > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : results
  task chk(input logic [47:0] seen, input logic [47:0] exp, input string what);
    compares++;
    if (seen !== exp)
    begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task xfer(input logic wr_en, input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    apb_i <= '{1'b1, 1'b0, wr_en, a, {24'h000000, d}};
    @(posedge core_clk);
    apb_i.penable <= 1'b1;
    @(posedge core_clk);
    while (pready !== 1'b1) @(posedge core_clk);
    v = prdata[7:0];
    se = pslverr;
    apb_i <= '0;
  endtask : xfer
  task wr(input logic [7:0] a, input logic [7:0] d);
    xfer(1'b1, a, d);
  endtask : wr
  task set2(input logic [7:0] a, input logic [7:0] p, input logic [7:0] c);
    wr(a, p);
    wr(a, c);
  endtask : set2
  task rdc(input logic [7:0] a, input logic [7:0] e, input string what);
    xfer(1'b0, a, 8'h00);
    chk(v, e, what);
  endtask : rdc
  task wirq;
    // Skip the edge the caller returned on, where a cleared flag still reads high
    @(posedge core_clk);
    while (intrq !== 1'b1) @(posedge core_clk);
    // One more edge so the interrupt monitor has counted the rise
    @(posedge core_clk);
  endtask : wirq
  task run(input logic [7:0] op, input int e);
    err_at = e;
    wi <= 0;
    src_on <= 1'b1;
    n0 = words;
    i0 = irqs;
    wr(adr_pkg::ADR_OFF_CMDSTAT, op);
    wirq();
    src_on <= 1'b0;
  endtask : run
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial
  begin
    repeat (2) @(posedge core_clk);
    sys_rst <= 1'b0;
    rdc(adr_pkg::ADR_OFF_CMDSTAT, 8'h40, "status");
    rdc(adr_pkg::ADR_OFF_ERROR, 8'h00, "error");
    xfer(1'b0, 8'h28, 8'h00);
    chk(se, 1'b1, "pslverr");
    set2(adr_pkg::ADR_OFF_SECNUM, 8'hAB, 8'h12);
    rdc(adr_pkg::ADR_OFF_SECNUM, 8'h12, "secnum cur");
    wr(adr_pkg::ADR_OFF_DEVCTL, 8'h80);
    rdc(adr_pkg::ADR_OFF_SECNUM, 8'hAB, "secnum prev");
    wr(adr_pkg::ADR_OFF_DEVCTL, 8'h00);
    set2(adr_pkg::ADR_OFF_SECCNT, 8'h00, 8'h01);
    set2(adr_pkg::ADR_OFF_CYLLO, 8'hCD, 8'h34);
    set2(adr_pkg::ADR_OFF_CYLHI, 8'hEF, 8'h56);
    wr(adr_pkg::ADR_OFF_DEVHEAD, 8'h40);
    run(adr_pkg::ADR_OP_READ_DMA_EXT, -1);
    chk(media_o.lba, 48'hEFCDAB563412, "lba48");
    chk(media_o.count, 17'h00001, "count48");
    chk(words - n0, 256, "words");
    chk(last, 16'h00FF, "last word");
    chk(irqs - i0, 1, "irqs");
    rdc(adr_pkg::ADR_OFF_CMDSTAT, 8'h40, "status");
    dly <= 4'h0;
    for (int i = 0; i < 2; i++)
    begin
      wr(adr_pkg::ADR_OFF_SECCNT, 8'h02);
      wr(adr_pkg::ADR_OFF_SECNUM, 8'h21);
      wr(adr_pkg::ADR_OFF_CYLLO, 8'h43);
      wr(adr_pkg::ADR_OFF_CYLHI, 8'h65);
      wr(adr_pkg::ADR_OFF_DEVHEAD, i ? 8'hA7 : 8'hE7);
      run(i ? adr_pkg::ADR_OP_READ_DMA_NR : adr_pkg::ADR_OP_READ_DMA, 256);
      chk(media_o.chs, i == 1, "chs");
      if (i == 0) chk(media_o.lba[27:0], 28'h7654321, "lba28");
      chk(irqs - i0, 1, "irqs");
      rdc(adr_pkg::ADR_OFF_SECCNT, 8'h01, "left");
      rdc(adr_pkg::ADR_OFF_SECNUM, 8'h21, "last sector");
      rdc(adr_pkg::ADR_OFF_ERROR, 8'h40, "unc");
      chk(words - n0, 256, "words");
      rdc(adr_pkg::ADR_OFF_CMDSTAT, 8'h41, "status");
    end
    wr(adr_pkg::ADR_OFF_FEATURE, 8'h00);
    wr(adr_pkg::ADR_OFF_SECCNT, 8'h98);
    wr(adr_pkg::ADR_OFF_CMDSTAT, adr_pkg::ADR_OP_READ_DMA_Q);
    wirq();
    chk(media_o.count, 17'h00100, "queued count");
    rdc(adr_pkg::ADR_OFF_SECCNT, 8'h9C, "release");
    rdc(adr_pkg::ADR_OFF_CMDSTAT, 8'h40, "srv clear");
    dready <= 1'b1;
    wirq();
    xfer(1'b0, adr_pkg::ADR_OFF_CMDSTAT, 8'h00);
    chk(v[4], 1'b1, "srv set");
    run(adr_pkg::ADR_OP_SERVICE, 0);
    chk(words - n0, 0, "no words");
    rdc(adr_pkg::ADR_OFF_SECCNT, 8'h9B, "complete");
    rdc(adr_pkg::ADR_OFF_CMDSTAT, 8'h41, "done");
    set2(adr_pkg::ADR_OFF_FEATURE, 8'h00, 8'h00);
    set2(adr_pkg::ADR_OFF_SECCNT, 8'h00, 8'hA8);
    set2(adr_pkg::ADR_OFF_SECNUM, 8'h01, 8'h02);
    set2(adr_pkg::ADR_OFF_CYLLO, 8'h03, 8'h04);
    set2(adr_pkg::ADR_OFF_CYLHI, 8'h05, 8'h06);
    run(adr_pkg::ADR_OP_READ_DMA_Q_EXT, 512);
    chk(media_o.count, 17'h10000, "queued ext count");
    chk(irqs - i0, 1, "no release");
    rdc(adr_pkg::ADR_OFF_SECCNT, 8'hAB, "tag");
    rdc(adr_pkg::ADR_OFF_SECNUM, 8'h04, "err lba low");
    wr(adr_pkg::ADR_OFF_DEVCTL, 8'h80);
    rdc(adr_pkg::ADR_OFF_SECNUM, 8'h01, "err lba high");
    rdc(adr_pkg::ADR_OFF_CYLHI, 8'h05, "err lba top");
    wr(adr_pkg::ADR_OFF_DEVCTL, 8'h00);
    rdc(adr_pkg::ADR_OFF_CMDSTAT, 8'h41, "status");
    set2(adr_pkg::ADR_OFF_SECNUM, 8'h00, 8'h80);
    set2(adr_pkg::ADR_OFF_CYLLO, 8'h00, 8'h03);
    wr(adr_pkg::ADR_OFF_SECCNT, 8'h01);
    run(adr_pkg::ADR_OP_READ_LOG_EXT, -1);
    chk(media_o.lba, 48'h000000800003, "log page");
    chk(media_o.count, 17'h00001, "log count");
    chk(irqs - i0, 1, "log irqs");
    results();
  end
endmodule : adr_read_handler_bench
`default_nettype wire
